// file: hw/bridge_secondary_cfg_pkg.sv
// Package: offsets, field positions, reset values and carriers for the secondary config registers
package bridge_secondary_cfg_pkg;

    // ------------------------------------------------------------------
    // Configuration dword and byte lanes
    // ------------------------------------------------------------------
    localparam logic [7:0]  SECONDARY_MASTER_LATENCY_OFFSET = 8'h1b;
    localparam logic [7:0]  IO_WINDOW_BOTTOM_OFFSET         = 8'h1c;
    localparam logic [7:0]  IO_WINDOW_TOP_OFFSET            = 8'h1d;
    localparam logic [7:0]  DOWNSTREAM_SIDE_STATUS_OFFSET   = 8'h1e;
    localparam logic [5:0]  LATENCY_DWORD_INDEX             = 6'h06;
    localparam logic [5:0]  WINDOW_DWORD_INDEX              = 6'h07;

    // ------------------------------------------------------------------
    // Field positions and fixed values
    // ------------------------------------------------------------------
    localparam int          LATENCY_LSB          = 24;
    localparam int          BOTTOM_NIBBLE_LSB    = 4;
    localparam int          TOP_NIBBLE_LSB       = 12;
    localparam int          STATUS_LSB           = 16;
    localparam logic [3:0]  IO_DECODE_32BIT      = 4'h1;
    localparam logic [11:0] IO_TOP_LOW_ONES      = 12'hfff;
    localparam logic [11:0] IO_BOTTOM_LOW_ZERO   = 12'h000;
    localparam logic [4:0]  STATUS_RSVD_LOW      = 5'h00;
    localparam logic        STATUS_66MHZ_CAPABLE = 1'b0;
    localparam logic        STATUS_RSVD_22       = 1'b0;
    localparam logic        STATUS_FAST_B2B      = 1'b1;
    localparam logic [1:0]  STATUS_DEVSEL_MEDIUM = 2'h1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  LATENCY_RESET        = 8'h00;
    localparam logic [3:0]  NIBBLE_RESET         = 4'h0;
    localparam logic [7:0]  COUNT_RESET          = 8'h00;

    // Sticky error flags, bit order as in the status halfword (bits 24, 27..31)
    typedef struct packed {
        logic detected_parity;
        logic received_system_error;
        logic received_master_abort;
        logic received_target_abort;
        logic signalled_target_abort;
        logic data_parity;
    } error_flags_type;

    localparam error_flags_type FLAGS_RESET = '0;

    // Configuration access from the primary side, one dword at a time
    typedef struct packed {
        logic        write;
        logic        read;
        logic [5:0]  dword_index;
        logic [3:0]  byte_enable;
        logic [31:0] write_data;
    } config_access_type;

    // Secondary bus events, each a one-cycle pulse except secondary_master, which is held as a level
    typedef struct packed {
        logic secondary_master;
        logic parity_error_seen;
        logic parity_error_detected;
        logic system_error_sampled;
        logic master_abort_received;
        logic target_abort_received;
        logic target_abort_signalled;
    } secondary_events_type;

    // Latency timer control state
    typedef enum logic [1:0] {
        LAT_IDLE    = 2'b00,
        LAT_RUNNING = 2'b01,
        LAT_EXPIRED = 2'b11
    } latency_state_type;

endpackage

// file: hw/bridge_secondary_cfg_regs.sv
// Secondary latency timer, I/O window decode and secondary status registers of a PCI-to-PCI bridge
`timescale 1ns/10ps
module bridge_secondary_cfg_regs (
    input  wire logic                                          clk_i,
    input  wire logic                                          reset_n_i,
    input  wire bridge_secondary_cfg_pkg::config_access_type   cfg_access_i,
    output logic [31:0]                                        cfg_read_data_o,
    input  wire bridge_secondary_cfg_pkg::secondary_events_type sec_events_i,
    input  wire logic                                          parity_response_enable_i,
    input  wire logic                                          frame_start_i,
    input  wire logic                                          data_transfer_i,
    input  wire logic                                          grant_i,
    input  wire logic                                          write_invalidate_i,
    output logic                                               latency_end_o,
    input  wire logic [15:0]                                   io_bottom_upper_i,
    input  wire logic [15:0]                                   io_top_upper_i,
    input  wire logic [31:0]                                   io_address_i,
    output logic                                               io_forward_o
);
    import bridge_secondary_cfg_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0]        latency_reg;
    logic [7:0]        latency_next;
    logic [3:0]        bottom_nibble_reg;
    logic [3:0]        bottom_nibble_next;
    logic [3:0]        top_nibble_reg;
    logic [3:0]        top_nibble_next;
    error_flags_type   flags_reg;
    error_flags_type   flags_next;
    error_flags_type   flags_set;
    error_flags_type   flags_clear;
    logic [31:0]       read_data_reg;
    logic [31:0]       read_data_next;
    latency_state_type lat_state_reg;
    latency_state_type lat_state_next;
    logic [7:0]        count_reg;
    logic [7:0]        count_next;
    logic              data_seen_reg;
    logic              data_seen_next;
    logic              forward_reg;
    logic              forward_next;
    logic [31:0]       window_bottom;
    logic [31:0]       window_top;
    logic [31:0]       latency_dword;
    logic [31:0]       window_dword;
    logic [15:0]       status_half;
    logic              hit_latency;
    logic              hit_window;

    // ------------------------------------------------------------------
    // Read views
    // ------------------------------------------------------------------
    always_comb begin
        hit_latency = (cfg_access_i.dword_index == LATENCY_DWORD_INDEX);
        hit_window  = (cfg_access_i.dword_index == WINDOW_DWORD_INDEX);
        status_half = {flags_reg.detected_parity,
                       flags_reg.received_system_error,
                       flags_reg.received_master_abort,
                       flags_reg.received_target_abort,
                       flags_reg.signalled_target_abort,
                       STATUS_DEVSEL_MEDIUM,
                       flags_reg.data_parity,
                       STATUS_FAST_B2B,
                       STATUS_RSVD_22,
                       STATUS_66MHZ_CAPABLE,
                       STATUS_RSVD_LOW};
        latency_dword = {latency_reg, 24'h00_0000};
        window_dword  = {status_half,
                         top_nibble_reg, IO_DECODE_32BIT,
                         bottom_nibble_reg, IO_DECODE_32BIT};
    end

    // ------------------------------------------------------------------
    // Writable fields
    // ------------------------------------------------------------------
    always_comb begin
        latency_next       = latency_reg;
        bottom_nibble_next = bottom_nibble_reg;
        top_nibble_next    = top_nibble_reg;
        flags_clear        = '0;
        if (cfg_access_i.write && hit_latency && cfg_access_i.byte_enable[3]) begin
            latency_next = cfg_access_i.write_data[LATENCY_LSB +: 8];
        end
        if (cfg_access_i.write && hit_window) begin
            if (cfg_access_i.byte_enable[0]) begin
                bottom_nibble_next = cfg_access_i.write_data[BOTTOM_NIBBLE_LSB +: 4];
            end
            if (cfg_access_i.byte_enable[1]) begin
                top_nibble_next = cfg_access_i.write_data[TOP_NIBBLE_LSB +: 4];
            end
            if (cfg_access_i.byte_enable[3]) begin
                flags_clear.detected_parity        = cfg_access_i.write_data[31];
                flags_clear.received_system_error  = cfg_access_i.write_data[30];
                flags_clear.received_master_abort  = cfg_access_i.write_data[29];
                flags_clear.received_target_abort  = cfg_access_i.write_data[28];
                flags_clear.signalled_target_abort = cfg_access_i.write_data[27];
                flags_clear.data_parity            = cfg_access_i.write_data[24];
            end
        end
    end

    // ------------------------------------------------------------------
    // Sticky error flags; a new event beats a same-cycle clear
    // ------------------------------------------------------------------
    always_comb begin
        flags_set.data_parity            = sec_events_i.secondary_master
                                         && sec_events_i.parity_error_seen
                                         && parity_response_enable_i;
        flags_set.signalled_target_abort = sec_events_i.target_abort_signalled;
        flags_set.received_target_abort  = sec_events_i.target_abort_received;
        flags_set.received_master_abort  = sec_events_i.master_abort_received;
        flags_set.received_system_error  = sec_events_i.system_error_sampled;
        flags_set.detected_parity        = sec_events_i.parity_error_detected;
        flags_next = flags_set | (flags_reg & ~flags_clear);
    end

    // ------------------------------------------------------------------
    // Read data, registered one cycle after the request
    // ------------------------------------------------------------------
    always_comb begin
        read_data_next = read_data_reg;
        if (cfg_access_i.read) begin
            if (hit_latency) begin
                read_data_next = latency_dword;
            end else if (hit_window) begin
                read_data_next = window_dword;
            end else begin
                read_data_next = 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------------
    // Secondary latency timer
    // ------------------------------------------------------------------
    // The count only matters against grant: holding the bus past expiry is
    // legal while grant stays, so expiry alone never cuts a transfer short.
    always_comb begin
        lat_state_next = lat_state_reg;
        count_next     = count_reg;
        data_seen_next = data_seen_reg;
        latency_end_o  = 1'b0;
        case (lat_state_reg)
            LAT_IDLE: begin
                if (frame_start_i) begin
                    count_next     = latency_reg;
                    data_seen_next = 1'b0;
                    lat_state_next = (latency_reg == LATENCY_RESET) ? LAT_EXPIRED : LAT_RUNNING;
                end
            end
            LAT_RUNNING: begin
                count_next = count_reg - 8'h01;
                if (count_reg == 8'h01) begin
                    lat_state_next = LAT_EXPIRED;
                end
                if (!sec_events_i.secondary_master) begin
                    lat_state_next = LAT_IDLE;
                end
            end
            LAT_EXPIRED: begin
                if (data_transfer_i) begin
                    data_seen_next = 1'b1;
                end
                latency_end_o = !grant_i && !write_invalidate_i
                              && (data_transfer_i || data_seen_reg);
                if (!sec_events_i.secondary_master) begin
                    lat_state_next = LAT_IDLE;
                end
            end
            default: begin
                lat_state_next = LAT_IDLE;
            end
        endcase
        if (frame_start_i && lat_state_reg != LAT_IDLE) begin
            count_next     = latency_reg;
            data_seen_next = 1'b0;
            lat_state_next = (latency_reg == LATENCY_RESET) ? LAT_EXPIRED : LAT_RUNNING;
        end
    end

    // ------------------------------------------------------------------
    // I/O window decode
    // ------------------------------------------------------------------
    always_comb begin
        window_bottom = {io_bottom_upper_i, bottom_nibble_reg, IO_BOTTOM_LOW_ZERO};
        window_top    = {io_top_upper_i, top_nibble_reg, IO_TOP_LOW_ONES};
        forward_next  = (io_address_i >= window_bottom)
                     && (io_address_i <= window_top);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            latency_reg       <= LATENCY_RESET;
            bottom_nibble_reg <= NIBBLE_RESET;
            top_nibble_reg    <= NIBBLE_RESET;
            flags_reg         <= FLAGS_RESET;
            read_data_reg     <= 32'h0000_0000;
            lat_state_reg     <= LAT_IDLE;
            count_reg         <= COUNT_RESET;
            data_seen_reg     <= 1'b0;
            forward_reg       <= 1'b0;
        end else begin
            latency_reg       <= latency_next;
            bottom_nibble_reg <= bottom_nibble_next;
            top_nibble_reg    <= top_nibble_next;
            flags_reg         <= flags_next;
            read_data_reg     <= read_data_next;
            lat_state_reg     <= lat_state_next;
            count_reg         <= count_next;
            data_seen_reg     <= data_seen_next;
            forward_reg       <= forward_next;
        end
    end

    assign cfg_read_data_o = read_data_reg;
    assign io_forward_o    = forward_reg;

endmodule

// file: test/cfg_master_model.sv
// Configuration master model: one dword access per call, driven on the falling edge
`timescale 1ns/10ps
module cfg_master_model (
    input  wire logic                                    clk_i,
    input  wire logic [31:0]                             read_data_i,
    output bridge_secondary_cfg_pkg::config_access_type  access_o
);
    import bridge_secondary_cfg_pkg::*;
    initial access_o = '0;
    // Call at a falling edge; idle lanes carry the inverse of the last access so stale values never look valid
    task automatic drive(input logic wr, input logic [5:0] idx, input logic [3:0] be, input logic [31:0] wd,
                         output logic [31:0] q);
        access_o = '{write: wr, read: !wr, dword_index: idx, byte_enable: be, write_data: wd};
        @(negedge clk_i);
        q = read_data_i;
        access_o = '{write: 1'b0, read: 1'b0, dword_index: ~idx, byte_enable: ~be, write_data: ~wd};
        @(negedge clk_i);
    endtask
endmodule

// file: test/bridge_secondary_cfg_regs_sva.sv
// Assertion checker for the secondary config registers
`timescale 1ns/10ps
module bridge_secondary_cfg_sva (
    input wire logic                                        clk_i,
    input wire logic                                        reset_n_i,
    input wire bridge_secondary_cfg_pkg::config_access_type cfg_access_i,
    input wire logic [31:0]                                 cfg_read_data_o,
    input wire bridge_secondary_cfg_pkg::secondary_events_type sec_events_i,
    input wire logic                                        grant_i,
    input wire logic                                        write_invalidate_i,
    input wire logic                                        latency_end_o
);
    import bridge_secondary_cfg_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    logic rd7;
    assign rd7 = cfg_access_i.read && (cfg_access_i.dword_index == WINDOW_DWORD_INDEX);
    property p_low_nibbles;
        rd7 |=> cfg_read_data_o[3:0] == 4'h1 && cfg_read_data_o[11:8] == 4'h1;
    endproperty
    a_low_nibbles: assert property (p_low_nibbles) else $error("window low nibble not 1");
    property p_reserved;
        rd7 |=> cfg_read_data_o[20:16] == 5'h00 && !cfg_read_data_o[22];
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved status bit set");
    property p_no_66;
        rd7 |=> !cfg_read_data_o[21];
    endproperty
    a_no_66: assert property (p_no_66) else $error("66 MHz bit set");
    property p_fast_b2b;
        rd7 |=> cfg_read_data_o[23];
    endproperty
    a_fast_b2b: assert property (p_fast_b2b) else $error("fast b2b bit clear");
    property p_devsel;
        rd7 |=> cfg_read_data_o[26:25] == 2'h1;
    endproperty
    a_devsel: assert property (p_devsel) else $error("devsel timing not medium");
    property p_serr_flag;
        sec_events_i.system_error_sampled ##1 rd7 |=> cfg_read_data_o[30];
    endproperty
    a_serr_flag: assert property (p_serr_flag) else $error("system error flag missing");
    property p_mabort_flag;
        sec_events_i.master_abort_received ##1 rd7 |=> cfg_read_data_o[29];
    endproperty
    a_mabort_flag: assert property (p_mabort_flag) else $error("master abort flag missing");
    property p_end_guard;
        latency_end_o |-> !grant_i && !write_invalidate_i;
    endproperty
    a_end_guard: assert property (p_end_guard) else $error("end while granted or invalidating");
    c_serr: cover property (sec_events_i.system_error_sampled ##1 rd7);
    c_end: cover property (latency_end_o);
    c_read: cover property (rd7);
endmodule
bind bridge_secondary_cfg_regs bridge_secondary_cfg_sva i_sva (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .cfg_access_i(cfg_access_i), .cfg_read_data_o(cfg_read_data_o), .sec_events_i(sec_events_i),
    .grant_i(grant_i), .write_invalidate_i(write_invalidate_i), .latency_end_o(latency_end_o));

// file: test/bridge_secondary_cfg_regs_bench.sv
// Self-checking bench for the secondary config registers
`timescale 1ns/10ps
module bridge_secondary_cfg_regs_bench;
    import bridge_secondary_cfg_pkg::*;
    logic                 clk_i = 1'b0;
    logic                 reset_n_i = 1'b0;
    config_access_type    acc;
    secondary_events_type ev = '0;
    logic [31:0]          rdata, d, addr = '0;
    logic                 pre = 1'b0, frame = 1'b0, xfer = 1'b0, gnt = 1'b0, wi = 1'b0, lat_end, fwd;
    int                   n_errors = 0, check_count = 0, cycles = 0;
    logic [31:0]          addrs [6] = '{32'h0001_2fff, 32'h0001_3000, 32'h0002_5fff, 32'h0002_6000,
                                        32'h0000_4000, 32'h0003_4000};
    logic                 fwds [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    always #4 clk_i = ~clk_i;
    bridge_secondary_cfg_regs i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .cfg_access_i(acc),
        .cfg_read_data_o(rdata), .sec_events_i(ev), .parity_response_enable_i(pre), .frame_start_i(frame),
        .data_transfer_i(xfer), .grant_i(gnt), .write_invalidate_i(wi), .latency_end_o(lat_end),
        .io_bottom_upper_i(16'h0001), .io_top_upper_i(16'h0002), .io_address_i(addr), .io_forward_o(fwd));
    cfg_master_model i_master (.clk_i(clk_i), .read_data_i(rdata), .access_o(acc));
    // ----------------------------------------------------------------
    // Access, compare and closing tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [5:0] idx, input logic [3:0] be, input logic [31:0] wd);
        logic [31:0] q;
        i_master.drive(1'b1, idx, be, wd, q);
    endtask
    task automatic rd(input logic [5:0] idx, output logic [31:0] q);
        i_master.drive(1'b0, idx, 4'h0, 32'h0000_0000, q);
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Pulse the events in e, expect the flag; zero write keeps it, one write clears it
    task automatic flag_test(input logic [6:0] e, input int b, input logic exp);
        ev = e;
        @(negedge clk_i);
        ev = '0;
        rd(WINDOW_DWORD_INDEX, d);
        check({31'h0, d[b]}, {31'h0, exp});
        if (exp) begin
            wr(WINDOW_DWORD_INDEX, 4'h8, 32'h0000_0000);
            rd(WINDOW_DWORD_INDEX, d);
            check({31'h0, d[b]}, 32'h1);
            wr(WINDOW_DWORD_INDEX, 4'h8, 32'h1 << b);
            rd(WINDOW_DWORD_INDEX, d);
            check({31'h0, d[b]}, 32'h0);
        end
    endtask
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_errors++;
            finish_test();
        end
    end
    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(negedge clk_i);
        reset_n_i = 1'b1;
        @(negedge clk_i);
        rd(WINDOW_DWORD_INDEX, d);
        check(d, 32'h0280_0101);
        rd(LATENCY_DWORD_INDEX, d);
        check(d, 32'h0000_0000);
        rd(6'h00, d);
        check(d, 32'h0000_0000);
        $display("test reset done");
        // Low nibbles written with ones must stay at 1h
        wr(WINDOW_DWORD_INDEX, 4'h3, 32'hffff_5f3f);
        rd(WINDOW_DWORD_INDEX, d);
        check(d, 32'h0280_5131);
        for (int i = 0; i < 6; i++) begin
            addr = addrs[i];
            @(negedge clk_i);
            check({31'h0, fwd}, {31'h0, fwds[i]});
        end
        $display("test window done");
        flag_test(7'h10, 31, 1'b1);
        flag_test(7'h08, 30, 1'b1);
        flag_test(7'h04, 29, 1'b1);
        flag_test(7'h02, 28, 1'b1);
        flag_test(7'h01, 27, 1'b1);
        flag_test(7'h60, 24, 1'b0);
        pre = 1'b1;
        flag_test(7'h60, 24, 1'b1);
        wr(WINDOW_DWORD_INDEX, 4'h8, 32'hffff_ffff);
        rd(WINDOW_DWORD_INDEX, d);
        check(d, 32'h0280_5131);
        $display("test flags done");
        wr(LATENCY_DWORD_INDEX, 4'h8, 32'h0300_0000);
        rd(LATENCY_DWORD_INDEX, d);
        check(d, 32'h0300_0000);
        wr(LATENCY_DWORD_INDEX, 4'h7, 32'hffff_ffff);
        rd(LATENCY_DWORD_INDEX, d);
        check(d, 32'h0300_0000);
        ev = 7'h40;
        xfer = 1'b1;
        frame = 1'b1;
        @(negedge clk_i);
        frame = 1'b0;
        check({31'h0, lat_end}, 32'h0);
        repeat (2) @(negedge clk_i);
        check({31'h0, lat_end}, 32'h0);
        @(negedge clk_i);
        check({31'h0, lat_end}, 32'h1);
        wi = 1'b1;
        #1 check({31'h0, lat_end}, 32'h0);
        @(negedge clk_i);
        wi = 1'b0;
        gnt = 1'b1;
        #1 check({31'h0, lat_end}, 32'h0);
        @(negedge clk_i);
        gnt = 1'b0;
        frame = 1'b1;
        @(negedge clk_i);
        frame = 1'b0;
        check({31'h0, lat_end}, 32'h0);
        ev = '0;
        @(negedge clk_i);
        wr(LATENCY_DWORD_INDEX, 4'h8, 32'h0000_0000);
        ev = 7'h40;
        xfer = 1'b0;
        frame = 1'b1;
        @(negedge clk_i);
        frame = 1'b0;
        check({31'h0, lat_end}, 32'h0);
        gnt = 1'b1;
        xfer = 1'b1;
        @(negedge clk_i);
        xfer = 1'b0;
        check({31'h0, lat_end}, 32'h0);
        gnt = 1'b0;
        #1 check({31'h0, lat_end}, 32'h1);
        $display("test latency done");
        finish_test();
    end
endmodule
